/* File: pkg/byte_stream_if.sv */
`timescale 1ns/1ps
interface byte_stream_if #(parameter int WIDTH = 16) (
  input wire logic clk,
  input wire logic rst_b
);
  logic [WIDTH-1:0] push_data;
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] pop_data;
  logic pop_valid;
  logic pop_ready;

  modport store (
    input clk, rst_b, push_data, push_valid, pop_ready,
    output push_ready, pop_data, pop_valid
  );
  modport client (
    output push_data, push_valid, pop_ready,
    input push_ready, pop_data, pop_valid
  );
endinterface

/* File: pkg/eeprom_pkg.sv */
package eeprom_pkg;

  // ----------------------------------------------------------------
  // Array and link geometry
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int PAGE_W = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W = ADDR_W + DATA_W;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // ----------------------------------------------------------------
  // Instruction codes, compared after the don't-care bit is masked
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_MASK = 8'hF7;
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_SET_LATCH = 8'h06;
  localparam logic [7:0] CMD_CLR_LATCH = 8'h04;
  localparam logic [7:0] CMD_READ_STATE = 8'h05;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int TWC_MAX_MS = 5;
  // A longest time rounds down to whole cycles.
  localparam int TWC_CYCLES = TWC_MAX_MS * (CLK_HZ / 1000);

  typedef enum logic [5:0] {
    ST_CMD = 6'h01,
    ST_ADDR = 6'h02,
    ST_WDATA = 6'h04,
    ST_RDATA = 6'h08,
    ST_RSTAT = 6'h10,
    ST_SKIP = 6'h20
  } link_state_t;

  function automatic logic cmd_is(input logic [7:0] code, input logic [7:0] ref_code);
    return (code & CMD_MASK) == ref_code;
  endfunction

endpackage

/* File: src/spi_eeprom_front.sv */
`timescale 1ns/1ps
module spi_eeprom_front
  import eeprom_pkg::*;
#(
  parameter int TWC_CYCLES_P = TWC_CYCLES
) (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic CS_B_IN,
  input wire logic SCK_IN,
  input wire logic SI_IN,
  input wire logic HOLD_B_IN,
  output logic SO_OUT,
  output logic SO_OE_OUT,
  output logic WRITE_BUSY_OUT,
  output logic WRITE_LATCH_OUT
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic cs_s1, cs_s2, cs_s3;
  logic sck_s1, sck_s2, sck_s3;
  logic si_s1, si_s2;
  logic hold_s1, hold_s2;

  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      {cs_s1, cs_s2, cs_s3} <= 3'h7;
      {sck_s1, sck_s2, sck_s3} <= 3'h0;
      {si_s1, si_s2} <= 2'h0;
      {hold_s1, hold_s2} <= 2'h3;
    end
    else
    begin
      {cs_s1, cs_s2, cs_s3} <= {CS_B_IN, cs_s1, cs_s2};
      {sck_s1, sck_s2, sck_s3} <= {SCK_IN, sck_s1, sck_s2};
      {si_s1, si_s2} <= {SI_IN, si_s1};
      {hold_s1, hold_s2} <= {HOLD_B_IN, hold_s1};
    end
  end

  // ----------------------------------------------------------------
  // Link decode
  // ----------------------------------------------------------------
  link_state_t state_reg, state_next;
  logic [2:0] cnt_reg;
  logic [7:0] in_sh_reg, cmd_reg, addr_reg, out_sh_reg;
  logic so_reg, so_oe_reg, wel_reg, busy_reg, got_data_reg, wr_phase_reg;
  logic [PAGE_W-1:0] wr_idx_reg;
  logic [31:0] twc_cnt_reg;
  logic [DATA_W-1:0] array_mem [2**ADDR_W];
  logic [DATA_W-1:0] page_mem [2**PAGE_W];
  logic [2**PAGE_W-1:0] page_valid_reg;
  logic [ADDR_W-PAGE_W-1:0] page_base_reg;

  // Edges are only seen while selected and not held, so a paused
  // transfer keeps its bit count and shift contents intact.
  wire active = ~cs_s2 & hold_s2;
  wire rise = active & sck_s2 & ~sck_s3;
  wire fall = active & ~sck_s2 & sck_s3;
  wire cs_rise = cs_s2 & ~cs_s3;
  wire byte_done = rise & (cnt_reg == LAST_BIT);
  wire [7:0] byte_in = {in_sh_reg[6:0], si_s2};
  wire is_out = (state_reg == ST_RDATA) | (state_reg == ST_RSTAT);
  wire [7:0] addr_inc = addr_reg + 8'h01;
  wire [7:0] status_byte = {6'h00, wel_reg, busy_reg};
  wire addr_is_read = cmd_is(cmd_reg, CMD_READ);
  wire commit = cs_rise & (state_reg == ST_WDATA) & got_data_reg & (cnt_reg == 3'h0)
    & wel_reg & ~busy_reg;
  wire latch_set = cs_rise & (state_reg == ST_SKIP) & (cnt_reg == 3'h0)
    & cmd_is(cmd_reg, CMD_SET_LATCH);
  wire latch_clr = cs_rise & (state_reg == ST_SKIP) & (cnt_reg == 3'h0)
    & cmd_is(cmd_reg, CMD_CLR_LATCH);
  wire twc_done = busy_reg & (twc_cnt_reg == 32'(TWC_CYCLES_P - 1));

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_CMD:
      begin
        if (byte_done)
        begin
          if (cmd_is(byte_in, CMD_READ)) state_next = busy_reg ? ST_SKIP : ST_ADDR;
          else if (cmd_is(byte_in, CMD_WRITE))
            state_next = (wel_reg & ~busy_reg) ? ST_ADDR : ST_SKIP;
          else if (cmd_is(byte_in, CMD_READ_STATE)) state_next = ST_RSTAT;
          else state_next = ST_SKIP;
        end
      end
      ST_ADDR:
      begin
        if (byte_done) state_next = addr_is_read ? ST_RDATA : ST_WDATA;
      end
      ST_WDATA, ST_RDATA, ST_RSTAT, ST_SKIP: state_next = state_reg;
      default: state_next = ST_SKIP;
    endcase
    if (cs_s2) state_next = ST_CMD;
  end

  // ----------------------------------------------------------------
  // Write staging through the FIFO
  // ----------------------------------------------------------------
  byte_stream_if #(.WIDTH(FIFO_W)) stage (.clk(CLK_IN), .rst_b(RST_B_IN));

  // A byte that finds the FIFO full is dropped; the drain runs every
  // cycle outside the commit phase, so that only happens on abuse.
  assign stage.push_valid = byte_done & (state_reg == ST_WDATA);
  assign stage.push_data = {addr_reg, byte_in};
  assign stage.pop_ready = ~wr_phase_reg;
  wire pop = stage.pop_valid & stage.pop_ready;
  wire [PAGE_W-1:0] pop_slot = stage.pop_data[DATA_W +: PAGE_W];

  stream_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) stage_fifo (.port(stage));

  wire page_clear = byte_done & (state_reg == ST_ADDR) & ~addr_is_read;

  always_ff @(posedge CLK_IN)
  begin
    if (pop) page_mem[pop_slot] <= stage.pop_data[DATA_W-1:0];
    if (wr_phase_reg & page_valid_reg[wr_idx_reg])
      array_mem[{page_base_reg, wr_idx_reg}] <= page_mem[wr_idx_reg];
  end

  // ----------------------------------------------------------------
  // Shift and address state
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      state_reg <= ST_CMD;
      cnt_reg <= 3'h0;
      in_sh_reg <= 8'h00;
      cmd_reg <= 8'h00;
      got_data_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (cs_s2) cnt_reg <= 3'h0;
      else if (rise) cnt_reg <= cnt_reg + 3'h1;
      if (rise) in_sh_reg <= byte_in;
      if (cs_s2) cmd_reg <= 8'h00;
      else if (byte_done & (state_reg == ST_CMD)) cmd_reg <= byte_in;
      if (cs_s2) got_data_reg <= 1'b0;
      else if (stage.push_valid) got_data_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      addr_reg <= 8'h00;
      out_sh_reg <= 8'h00;
      so_reg <= 1'b0;
      so_oe_reg <= 1'b0;
    end
    else
    begin
      if (byte_done & (state_reg == ST_ADDR))
      begin
        addr_reg <= byte_in;
        out_sh_reg <= array_mem[byte_in];
      end
      else if (byte_done & (state_reg == ST_CMD))
        out_sh_reg <= status_byte;
      else if (byte_done & (state_reg == ST_RDATA))
      begin
        addr_reg <= addr_inc;
        out_sh_reg <= array_mem[addr_inc];
      end
      else if (byte_done & (state_reg == ST_RSTAT))
        out_sh_reg <= status_byte;
      else if (fall & is_out)
        out_sh_reg <= {out_sh_reg[6:0], 1'b0};
      else if (stage.push_valid)
        addr_reg <= {addr_reg[ADDR_W-1:PAGE_W], addr_reg[PAGE_W-1:0] + 4'h1};
      if (fall & is_out) so_reg <= out_sh_reg[7];
      so_oe_reg <= active & is_out;
    end
  end

  // ----------------------------------------------------------------
  // Write latch and self-timed write cycle
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      wel_reg <= 1'b0;
      busy_reg <= 1'b0;
      wr_phase_reg <= 1'b0;
      wr_idx_reg <= '0;
      twc_cnt_reg <= 32'h0;
      page_valid_reg <= '0;
      page_base_reg <= '0;
    end
    else
    begin
      // A set request in the same cycle as a clear wins.
      if (latch_set) wel_reg <= 1'b1;
      else if (latch_clr | twc_done) wel_reg <= 1'b0;
      if (commit) busy_reg <= 1'b1;
      else if (twc_done) busy_reg <= 1'b0;
      twc_cnt_reg <= (busy_reg & ~twc_done) ? twc_cnt_reg + 32'h1 : 32'h0;
      // The array is updated only after the FIFO has drained into the page.
      if (busy_reg & ~wr_phase_reg & ~stage.pop_valid & (wr_idx_reg == '0))
        wr_phase_reg <= 1'b1;
      else if (wr_phase_reg & (wr_idx_reg == PAGE_W'(2**PAGE_W - 1)))
        wr_phase_reg <= 1'b0;
      if (wr_phase_reg) wr_idx_reg <= wr_idx_reg + 4'h1;
      // A byte that lands with a clear keeps its slot, so the set wins.
      if (page_clear | twc_done) page_valid_reg <= '0;
      if (pop)
      begin
        page_valid_reg[pop_slot] <= 1'b1;
        page_base_reg <= stage.pop_data[FIFO_W-1 -: ADDR_W-PAGE_W];
      end
    end
  end

  assign SO_OUT = so_reg;
  assign SO_OE_OUT = so_oe_reg;
  assign WRITE_BUSY_OUT = busy_reg;
  assign WRITE_LATCH_OUT = wel_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);

  inst_shift_a: assert property (rise |=> in_sh_reg[0] == $past(si_s2))
    else $error("Input bit not captured on rising edge.");
  first_bit_a: assert property (cs_s2 |=> cnt_reg == 3'h0 && state_reg == ST_CMD)
    else $error("Deselect did not rearm the bit counter.");
  msb_out_a: assert property (fall && is_out |=> so_reg == $past(out_sh_reg[7]))
    else $error("Output bit not taken from the top of the shifter.");
  out_fall_a: assert property (!fall |=> $stable(so_reg))
    else $error("Output moved without a falling clock edge.");
  hold_freeze_a: assert property (!hold_s2 && !cs_s2 |=> $stable(cnt_reg)
    && $stable(in_sh_reg) && $stable(addr_reg))
    else $error("Transfer state moved while held.");
  hold_quiet_a: assert property (!hold_s2 |=> !so_oe_reg)
    else $error("Output driven while held.");
  decode_a: assert property (byte_done && state_reg == ST_CMD
    && cmd_is(byte_in, CMD_READ_STATE) |=> state_reg == ST_RSTAT)
    else $error("Status read instruction not decoded.");
  addr_wrap_a: assert property (byte_done && state_reg == ST_RDATA && addr_reg == 8'hFF
    |=> addr_reg == 8'h00)
    else $error("Read pointer did not wrap to zero.");
  busy_start_a: assert property (commit |=> busy_reg ##1 busy_reg)
    else $error("Write cycle did not start on deselect.");
  busy_bound_a: assert property (busy_reg |-> twc_cnt_reg < 32'(TWC_CYCLES_P))
    else $error("Write cycle overran its limit.");

  read_byte_c: cover property (byte_done && state_reg == ST_RDATA);
  commit_c: cover property (commit);
  hold_c: cover property (!hold_s2 && !cs_s2 && state_reg == ST_RDATA);
  status_c: cover property (byte_done && state_reg == ST_RSTAT);

endmodule // spi_eeprom_front

/* File: src/stream_fifo.sv */
`timescale 1ns/1ps
module stream_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  byte_stream_if.store port
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;

  wire do_push = port.push_valid & port.push_ready;
  wire do_pop = port.pop_valid & port.pop_ready;
  wire [AW-1:0] wr_ptr_next = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
  wire [AW-1:0] rd_ptr_next = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;

  assign port.push_ready = (count_reg != (AW + 1)'(DEPTH));
  assign port.pop_valid = (count_reg != '0);
  assign port.pop_data = mem[rd_ptr_reg];

  always_ff @(posedge port.clk)
  begin
    if (do_push)
    begin
      mem[wr_ptr_reg] <= port.push_data;
    end
  end

  always_ff @(posedge port.clk or negedge port.rst_b)
  begin
    if (!port.rst_b)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (do_push) wr_ptr_reg <= wr_ptr_next;
      if (do_pop) rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_reg + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
    end
  end

  fifo_bound_a: assert property (@(posedge port.clk) disable iff (!port.rst_b)
    count_reg <= (AW + 1)'(DEPTH))
    else $error("FIFO count above depth.");
  fifo_full_c: cover property (@(posedge port.clk) disable iff (!port.rst_b)
    !port.push_ready);
endmodule // stream_fifo

/* File: verif/spi_eeprom_serial_front_end_tb.sv */
`timescale 1ns/1ps
module spi_eeprom_serial_front_end_tb;
  import eeprom_pkg::*;
  localparam int TWC_P = 512;
  logic clk, rst_b, cs_b, sck, si, hold_b, so, so_oe, busy, latch, junk, so_wire;
  logic [7:0] mem [256];
  logic [7:0] rx, a;
  integer seed = 32'hd1b637b4;
  int failures = 0;
  int compares = 0;

  // ----------------------------------------------------------------
  // Clock, released data line and instances
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    junk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) junk <= ~junk;
  // A released output shows a changing level, never the last bit.
  assign so_wire = so_oe ? so : junk;

  spi_eeprom_front #(.TWC_CYCLES_P(TWC_P)) u_spi_eeprom_front (
    .CLK_IN(clk), .RST_B_IN(rst_b), .CS_B_IN(cs_b), .SCK_IN(sck), .SI_IN(si),
    .HOLD_B_IN(hold_b), .SO_OUT(so), .SO_OE_OUT(so_oe), .WRITE_BUSY_OUT(busy),
    .WRITE_LATCH_OUT(latch));
  spi_host_model u_spi_host_model (
    .clk_in(clk), .so_in(so_wire), .cs_b_out(cs_b), .sck_out(sck), .si_out(si),
    .hold_b_out(hold_b));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] rnd8();
    return 8'($random(seed));
  endfunction

  function automatic logic [7:0] status_exp(input logic wel, input logic wip);
    return {6'h00, wel, wip};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic latch_frame(input logic en);
    u_spi_host_model.start();
    u_spi_host_model.xfer((en ? CMD_SET_LATCH : CMD_CLR_LATCH) | (rnd8() & 8'h08), 8, rx);
    u_spi_host_model.stop();
    chk(8'(latch), 8'(en));
    u_spi_host_model.start();
    u_spi_host_model.xfer(CMD_READ_STATE, 8, rx);
    u_spi_host_model.xfer(rnd8(), 8, rx);
    u_spi_host_model.stop();
    chk(rx, status_exp(en, 1'b0));
  endtask

  // Without the latch the frame must leave the array alone.
  task automatic write_bytes(input logic [7:0] wa, input int n, input logic en);
    int cnt;
    logic [7:0] d;
    latch_frame(en);
    u_spi_host_model.start();
    u_spi_host_model.xfer(CMD_WRITE | (rnd8() & 8'h08), 8, rx);
    u_spi_host_model.xfer(wa, 8, rx);
    for (int i = 0; i < n; i++)
    begin
      d = rnd8();
      if (en)
        mem[{wa[7:4], wa[3:0] + 4'(i)}] = d;
      u_spi_host_model.xfer(d, 8, rx);
    end
    u_spi_host_model.stop();
    chk(8'(busy), 8'(en));
    if (en)
    begin
      // Status stays readable during the write; an array read is refused.
      u_spi_host_model.start();
      u_spi_host_model.xfer(CMD_READ_STATE, 8, rx);
      u_spi_host_model.xfer(rnd8(), 8, rx);
      u_spi_host_model.stop();
      chk(rx, status_exp(1'b1, 1'b1));
      u_spi_host_model.start();
      u_spi_host_model.xfer(CMD_READ, 8, rx);
      u_spi_host_model.xfer(wa, 8, rx);
      u_spi_host_model.xfer(rnd8(), 8, rx);
      chk(8'(so_oe), 8'h00);
      u_spi_host_model.stop();
    end
    cnt = 0;
    while (busy === 1'b1 && cnt < 4 * TWC_P)
    begin
      @(posedge clk);
      cnt++;
    end
    chk(8'(cnt <= TWC_P), 8'h01);
    chk(8'(latch), 8'h00);
  endtask

  task automatic read_check(input logic [7:0] ra, input int n, input int hold_byte);
    u_spi_host_model.start();
    u_spi_host_model.xfer(CMD_READ | (rnd8() & 8'h08), int'(rnd8() % 8), rx);
    u_spi_host_model.xfer(ra, 8, rx);
    for (int i = 0; i < n; i++)
    begin
      u_spi_host_model.xfer(rnd8(), (i == hold_byte) ? int'(rnd8() % 8) : 8, rx);
      chk(rx, mem[8'(ra + i)]);
    end
    u_spi_host_model.stop();
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    rst_b = 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk({4'h0, so_oe, so, busy, latch}, 8'h00);
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    write_bytes(8'hF0, 16, 1'b1);
    write_bytes(8'h00, 16, 1'b1);
    read_check(8'hF8, 16, 3);
    latch_frame(1'b1);
    write_bytes(8'hF4, 3, 1'b0);
    read_check(8'hF0, 16, 8);
    for (int k = 0; k < 6; k++)
    begin
      a = rnd8();
      a[7:4] = {4{a[7]}};
      write_bytes(a, 1 + int'(rnd8() % 16), 1'b1);
      read_check({a[7:4], 4'h0}, 16, int'(rnd8() % 16));
    end
    summarize();
  end

  initial
  begin
    #2_000_000;
    failures++;
    summarize();
  end
endmodule  // spi_eeprom_serial_front_end_tb

/* File: verif/spi_host_model.sv */
`timescale 1ns/1ps
module spi_host_model (
  input wire logic clk_in,
  input wire logic so_in,
  output logic cs_b_out,
  output logic sck_out,
  output logic si_out,
  output logic hold_b_out
);
  // ----------------------------------------------------------------
  // Link idle levels
  // ----------------------------------------------------------------
  initial
  begin
    cs_b_out = 1'b1;
    sck_out = 1'b0;
    si_out = 1'b0;
    hold_b_out = 1'b1;
  end

  // ----------------------------------------------------------------
  // Frame tasks; each half of the serial clock lasts 4 system clocks
  // ----------------------------------------------------------------
  task automatic start();
    @(posedge clk_in);
    cs_b_out <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask

  // A bit index in hold_bit pauses the link just before that bit.
  task automatic xfer(input logic [7:0] tx, input int hold_bit, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      si_out <= tx[i];
      repeat (4) @(posedge clk_in);
      // Hold waits out the last falling edge, so the output still advances.
      if (i == hold_bit)
      begin
        hold_b_out <= 1'b0;
        repeat (4) @(posedge clk_in);
        // Clock and data wander while paused, as on a shared bus.
        repeat (6)
        begin
          sck_out <= ~sck_out;
          si_out <= ~si_out;
          repeat (4) @(posedge clk_in);
        end
        hold_b_out <= 1'b1;
        si_out <= tx[i];
        repeat (4) @(posedge clk_in);
      end
      sck_out <= 1'b1;
      repeat (3) @(posedge clk_in);
      // Sampled late in the high phase, well clear of the output update.
      @(negedge clk_in);
      rx[i] = so_in;
      @(posedge clk_in);
      sck_out <= 1'b0;
    end
  endtask

  task automatic stop();
    repeat (4) @(posedge clk_in);
    cs_b_out <= 1'b1;
    si_out <= ~si_out;
    repeat (8) @(posedge clk_in);
  endtask
endmodule  // spi_host_model
